// ### irp_pkg.sv
// Constants, types and register map of the input reference pre-divider
package irp_pkg;
    localparam int unsigned IRP_CLK_NS   = 4;
    localparam int unsigned IRP_FRAME_NS = 125000;
    localparam int unsigned IRP_FRAME_CYC = IRP_FRAME_NS / IRP_CLK_NS;
    localparam int unsigned IRP_ACT_UNIT = 256;

    localparam logic [7:0] IRP_OFS_TEST    = 8'h03;
    localparam logic [7:0] IRP_OFS_STAT    = 8'h0C;
    localparam logic [7:0] IRP_OFS_SELST   = 8'h0D;
    localparam logic [7:0] IRP_OFS_PRIO_M  = 8'h18;
    localparam logic [7:0] IRP_OFS_PRIO_A  = 8'h1A;
    localparam logic [7:0] IRP_OFS_MONCFG  = 8'h30;
    localparam logic [7:0] IRP_OFS_INMODE  = 8'h34;
    localparam logic [7:0] IRP_OFS_DIV_LO  = 8'h46;
    localparam logic [7:0] IRP_OFS_DIV_HI  = 8'h47;
    localparam logic [7:0] IRP_OFS_PATH    = 8'h4B;
    localparam logic [7:0] IRP_OFS_BUCKET  = 8'h50;
    localparam logic [7:0] IRP_FREQ_OFS [4] = '{8'h22, 8'h23, 8'h27, 8'h28};

    localparam int unsigned IRP_NET_BIT   = 2;
    localparam int unsigned IRP_EDGE_BIT  = 2;
    localparam int unsigned IRP_AUTO_BIT  = 6;
    localparam int unsigned IRP_MAN_BIT   = 7;
    localparam int unsigned IRP_AUX_FOLLOW_BIT = 6;

    localparam logic [3:0] IRP_CHAN_ID   [4] = '{4'h3, 4'h4, 4'h8, 4'h9};
    localparam logic [3:0] IRP_PRIO_RST  [4] = '{4'h2, 4'h3, 4'h4, 4'h5};
    localparam logic [7:0] IRP_FREQ_RST  [4] = '{8'h00, 8'h00, 8'h03, 8'h03};
    localparam logic [7:0] IRP_MONCFG_RST = 8'hAA;
    localparam logic [7:0] IRP_BUCKET_RST = 8'h20;
    localparam logic [3:0] IRP_CODE_8K    = 4'h0;

    // Ratio to 8 kHz per frequency code; code 1 depends on network type
    localparam logic [13:0] IRP_RATIO_DS1 = 14'h00C1;
    localparam logic [13:0] IRP_RATIO_E1  = 14'h0100;
    localparam logic [13:0] IRP_AUTO_RATIO [16] = '{
        14'h0001, 14'h0000, 14'h032A, 14'h097E, 14'h0CA8, 14'h12FC,
        14'h1950, 14'h25F8, 14'h0001, 14'h0001, 14'h0001, 14'h0001,
        14'h0001, 14'h0001, 14'h0001, 14'h0001};

    typedef enum logic [1:0] {
        IRP_MODE_DIRECT = 2'b00,
        IRP_MODE_AUTO   = 2'b01,
        IRP_MODE_MANUAL = 2'b10
    } irp_mode_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irp_reg_req_t;

    typedef struct packed {
        logic       ok;
        logic [3:0] id;
    } irp_sel_t;
endpackage

// ### irp_edge_divider.sv
// Per-input edge detector and pre-divider
`timescale 1ns/1ps
module irp_edge_divider (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Reference and setup
    input  wire logic             ref_in,
    input  wire logic             edge_fall,
    input  irp_pkg::irp_mode_t    mode,
    input  wire logic [13:0]      ratio,
    input  wire logic             reload,
    // Results
    output logic                  edge_seen,
    output logic                  ref_event
);
    import irp_pkg::*;

    logic        ref_prev;
    logic [13:0] count;
    logic        hit;

    assign hit = edge_fall ? (ref_prev & ~ref_in) : (~ref_prev & ref_in);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ref_prev  <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            ref_prev  <= ref_in;
            edge_seen <= hit;
        end
    end

    // A rewrite of N restarts the count so no stale long period escapes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count     <= 14'h0000;
            ref_event <= 1'b0;
        end else if (reload) begin
            count     <= 14'h0000;
            ref_event <= 1'b0;
        end else if (hit && mode == IRP_MODE_DIRECT) begin
            ref_event <= 1'b1;
        end else if (hit && count >= ratio - 14'h0001) begin
            count     <= 14'h0000;
            ref_event <= 1'b1;
        end else if (hit) begin
            count     <= count + 14'h0001;
            ref_event <= 1'b0;
        end else begin
            ref_event <= 1'b0;
        end
    end
endmodule

// ### irp_selector.sv
// Priority based reference selection for one timing path
`timescale 1ns/1ps
module irp_selector (
    // Candidates
    input  wire logic [3:0]       valid,
    input  wire logic [3:0][3:0]  prio,
    // Forced selection
    input  wire logic             force_en,
    input  wire logic [1:0]       force_idx,
    // Result
    output logic [1:0]            sel_idx,
    output logic                  sel_ok
);
    import irp_pkg::*;

    logic [3:0] best;

    // Priority 1 is highest; 0 removes the input; ties go to the lower input
    always_comb begin
        sel_idx = 2'b00;
        sel_ok  = 1'b0;
        best    = 4'hF;
        if (force_en) begin
            sel_idx = force_idx;
            sel_ok  = valid[force_idx];
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (valid[i] && prio[i] != 4'h0 && (!sel_ok || prio[i] < best)) begin
                    sel_idx = 2'(i);
                    sel_ok  = 1'b1;
                    best    = prio[i];
                end
            end
        end
    end
endmodule

// ### irp_predivider.sv
// Input reference front end: config registers, dividers, monitors, selection
`timescale 1ns/1ps
module irp_predivider #(
    parameter int unsigned FRAME_CYCLES = irp_pkg::IRP_FRAME_CYC
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    // Reference pins
    input  wire logic [3:0]           ref_in,
    input  wire logic                 sync_align_input,
    input  wire logic                 network_type_pin,
    // Register port
    input  irp_pkg::irp_reg_req_t     reg_req,
    output logic [7:0]                reg_rd_data,
    // To the timing paths
    output logic                      main_ref_event,
    output logic                      aux_ref_event,
    output irp_pkg::irp_sel_t         main_sel,
    output irp_pkg::irp_sel_t         aux_sel,
    // Frame and multiframe pulses
    output logic                      frame_pulse,
    output logic                      mframe_pulse
);
    import irp_pkg::*;

    localparam int unsigned HARD_TOL = FRAME_CYCLES / 64;
    localparam int unsigned SOFT_TOL = FRAME_CYCLES / 256;
    localparam logic [15:0] FRAME_C  = 16'(FRAME_CYCLES);
    localparam logic [15:0] HARD_C   = 16'(HARD_TOL);
    localparam logic [15:0] SOFT_C   = 16'(SOFT_TOL);

    logic [7:0]       freq_cfg [4];
    logic [3:0][3:0]  prio_main;
    logic [3:0][3:0]  prio_aux;
    logic [7:0]       mon_cfg;
    logic [7:0]       bucket_cfg [4];
    logic [13:0]      shared_divide_value;
    logic             div_reload;
    logic             network_type_bit;
    logic             strap_pending;
    logic             divided_lock_edge_select;
    logic [6:0]       path_cfg;
    logic [3:0]       ref_valid;
    logic [3:0]       soft_flag;
    logic [3:0]       edge_seen;
    logic [3:0]       ref_event;
    logic [1:0]       main_idx;
    logic [1:0]       aux_idx;
    logic             main_ok;
    logic             aux_ok;
    logic             wr;
    logic [7:0]       wa;
    logic [7:0]       wd;

    assign wr = reg_req.wr;
    assign wa = reg_req.addr;
    assign wd = reg_req.wdata;

    // Network type is caught from the pin on the first edge after release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strap_pending    <= 1'b1;
            network_type_bit <= 1'b0;
        end else if (strap_pending) begin
            strap_pending    <= 1'b0;
            network_type_bit <= network_type_pin;
        end else if (wr && wa == IRP_OFS_INMODE) begin
            network_type_bit <= wd[IRP_NET_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            divided_lock_edge_select <= 1'b0;
        end else if (wr && wa == IRP_OFS_TEST) begin
            divided_lock_edge_select <= wd[IRP_EDGE_BIT];
        end
    end

    // Reset rates do not depend on the network type
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                freq_cfg[i] <= IRP_FREQ_RST[i];
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr && wa == IRP_FREQ_OFS[i]) begin
                    freq_cfg[i] <= wd;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 4; i++) begin
                prio_main[i] <= IRP_PRIO_RST[i];
                prio_aux[i]  <= IRP_PRIO_RST[i];
            end
        end else if (wr) begin
            for (int i = 0; i < 4; i += 2) begin
                if (wa == IRP_OFS_PRIO_M + 8'(i / 2)) begin
                    prio_main[i]     <= wd[3:0];
                    prio_main[i + 1] <= wd[7:4];
                end
                if (wa == IRP_OFS_PRIO_A + 8'(i / 2)) begin
                    prio_aux[i]      <= wd[3:0];
                    prio_aux[i + 1]  <= wd[7:4];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mon_cfg  <= IRP_MONCFG_RST;
            path_cfg <= 7'h00;
            for (int i = 0; i < 4; i++) begin
                bucket_cfg[i] <= IRP_BUCKET_RST;
            end
        end else if (wr) begin
            if (wa == IRP_OFS_MONCFG) begin
                mon_cfg <= wd;
            end
            if (wa == IRP_OFS_PATH) begin
                path_cfg <= wd[6:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (wa == IRP_OFS_BUCKET + 8'(i)) begin
                    bucket_cfg[i] <= wd;
                end
            end
        end
    end

    // One N serves every input; either byte write restarts the dividers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shared_divide_value <= 14'h0001;
            div_reload          <= 1'b0;
        end else begin
            div_reload <= wr && (wa == IRP_OFS_DIV_LO || wa == IRP_OFS_DIV_HI);
            if (wr && wa == IRP_OFS_DIV_LO) begin
                shared_divide_value[7:0] <= wd;
            end
            if (wr && wa == IRP_OFS_DIV_HI) begin
                shared_divide_value[13:8] <= wd[5:0];
            end
        end
    end

    // Per-input divider and monitor
    generate
        for (genvar g = 0; g < 4; g++) begin : g_in
            irp_mode_t   mode;
            logic [13:0] ratio;
            logic [3:0]  code;
            logic [1:0]  mon_mode;
            logic [15:0] idle_cnt;
            logic [15:0] idle_lim;
            logic [15:0] per_cnt;
            logic [15:0] dev;
            logic        act_ok;
            logic        hard_bad;
            logic        freq_en;

            assign code     = freq_cfg[g][3:0];
            assign mon_mode = mon_cfg[2 * g +: 2];
            assign idle_lim = 16'(bucket_cfg[freq_cfg[g][5:4]] * IRP_ACT_UNIT) + 16'h00FF;

            always_comb begin
                if (freq_cfg[g][IRP_MAN_BIT]) begin
                    mode  = IRP_MODE_MANUAL;
                    ratio = shared_divide_value + 14'h0001;
                end else if (freq_cfg[g][IRP_AUTO_BIT]) begin
                    mode  = IRP_MODE_AUTO;
                    if (code == 4'h1) begin
                        ratio = network_type_bit ? IRP_RATIO_DS1 : IRP_RATIO_E1;
                    end else begin
                        ratio = IRP_AUTO_RATIO[code];
                    end
                end else begin
                    mode  = IRP_MODE_DIRECT;
                    ratio = 14'h0001;
                end
            end

            irp_edge_divider u_div (
                .core_clk  (core_clk),
                .rstn      (rstn),
                .ref_in    (ref_in[g]),
                .edge_fall (divided_lock_edge_select),
                .mode      (mode),
                .ratio     (ratio),
                .reload    (div_reload),
                .edge_seen (edge_seen[g]),
                .ref_event (ref_event[g])
            );

            // Frequency is only judged where the divided rate is 8 kHz
            assign freq_en = mon_mode[1] && (mode != IRP_MODE_DIRECT || code == IRP_CODE_8K);
            assign dev = (per_cnt > FRAME_C) ? per_cnt - FRAME_C : FRAME_C - per_cnt;

            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    idle_cnt <= 16'h0000;
                    act_ok   <= 1'b0;
                end else if (edge_seen[g]) begin
                    idle_cnt <= 16'h0000;
                    act_ok   <= 1'b1;
                end else if (idle_cnt >= idle_lim) begin
                    act_ok   <= 1'b0;
                end else begin
                    idle_cnt <= idle_cnt + 16'h0001;
                end
            end

            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    per_cnt      <= 16'h0000;
                    hard_bad     <= 1'b0;
                    soft_flag[g] <= 1'b0;
                end else if (ref_event[g]) begin
                    per_cnt      <= 16'h0001;
                    hard_bad     <= dev > HARD_C;
                    soft_flag[g] <= dev > SOFT_C;
                end else if (per_cnt > FRAME_C + HARD_C) begin
                    hard_bad     <= 1'b1;
                    soft_flag[g] <= 1'b1;
                end else begin
                    per_cnt <= per_cnt + 16'h0001;
                end
            end

            // A disabled monitor leaves the input eligible
            assign ref_valid[g] = (mon_mode == 2'b00)
                || (act_ok && !(freq_en && hard_bad));
        end
    endgenerate

    irp_selector u_main (
        .valid     (ref_valid),
        .prio      (prio_main),
        .force_en  (path_cfg[0]),
        .force_idx (path_cfg[2:1]),
        .sel_idx   (main_idx),
        .sel_ok    (main_ok)
    );

    irp_selector u_aux (
        .valid     (ref_valid),
        .prio      (prio_aux),
        .force_en  (path_cfg[3]),
        .force_idx (path_cfg[5:4]),
        .sel_idx   (aux_idx),
        .sel_ok    (aux_ok)
    );

    // 8 kHz and 2 kHz dividers, realigned by the sync input rising edge
    logic        sync_prev;
    logic [15:0] frame_cnt;
    logic [1:0]  mframe_cnt;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_prev    <= 1'b0;
            frame_cnt    <= 16'h0000;
            mframe_cnt   <= 2'b00;
            frame_pulse  <= 1'b0;
            mframe_pulse <= 1'b0;
        end else begin
            sync_prev <= sync_align_input;
            if (sync_align_input && !sync_prev) begin
                frame_cnt    <= 16'h0000;
                mframe_cnt   <= 2'b00;
                frame_pulse  <= 1'b1;
                mframe_pulse <= 1'b1;
            end else if (frame_cnt == FRAME_C - 16'h0001) begin
                frame_cnt    <= 16'h0000;
                mframe_cnt   <= mframe_cnt + 2'b01;
                frame_pulse  <= 1'b1;
                mframe_pulse <= mframe_cnt == 2'b11;
            end else begin
                frame_cnt    <= frame_cnt + 16'h0001;
                frame_pulse  <= 1'b0;
                mframe_pulse <= 1'b0;
            end
        end
    end

    // Aux following main uses the 8 kHz frame pulse and the main selection, not its own input
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            main_ref_event <= 1'b0;
            aux_ref_event  <= 1'b0;
            main_sel       <= '0;
            aux_sel        <= '0;
        end else begin
            main_ref_event <= main_ok && ref_event[main_idx];
            main_sel       <= '{ok: main_ok, id: IRP_CHAN_ID[main_idx]};
            if (path_cfg[IRP_AUX_FOLLOW_BIT]) begin
                aux_ref_event <= frame_pulse;
                aux_sel       <= '{ok: main_ok, id: IRP_CHAN_ID[main_idx]};
            end else begin
                aux_ref_event <= aux_ok && ref_event[aux_idx];
                aux_sel       <= '{ok: aux_ok, id: IRP_CHAN_ID[aux_idx]};
            end
        end
    end

    // Read data registered from the address; unmapped reads return zero
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < 4; i++) begin
            if (wa == IRP_FREQ_OFS[i]) begin
                rd_mux = freq_cfg[i];
            end
            if (wa == IRP_OFS_BUCKET + 8'(i)) begin
                rd_mux = bucket_cfg[i];
            end
        end
        unique case (wa)
            IRP_OFS_TEST:       rd_mux = 8'(divided_lock_edge_select) << IRP_EDGE_BIT;
            IRP_OFS_STAT:       rd_mux = {soft_flag, ref_valid};
            IRP_OFS_SELST:      rd_mux = {main_sel.id, aux_sel.id};
            IRP_OFS_PRIO_M:     rd_mux = {prio_main[1], prio_main[0]};
            8'h19:              rd_mux = {prio_main[3], prio_main[2]};
            IRP_OFS_PRIO_A:     rd_mux = {prio_aux[1], prio_aux[0]};
            8'h1B:              rd_mux = {prio_aux[3], prio_aux[2]};
            IRP_OFS_MONCFG:     rd_mux = mon_cfg;
            IRP_OFS_INMODE:     rd_mux = 8'(network_type_bit) << IRP_NET_BIT;
            IRP_OFS_DIV_LO:     rd_mux = shared_divide_value[7:0];
            IRP_OFS_DIV_HI:     rd_mux = {2'b00, shared_divide_value[13:8]};
            IRP_OFS_PATH:       rd_mux = {1'b0, path_cfg};
            default:            ;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rd_data <= 8'h00;
        end else begin
            reg_rd_data <= rd_mux;
        end
    end
endmodule

// ### irp_ref_src.sv
// Reference clock sources and sync pulse driving the pre-divider pins
`timescale 1ns/1ps
module irp_ref_src (
    // Clock
    input  wire logic       core_clk,
    // Pins
    output logic [3:0]      ref_in,
    output logic            sync_align_input
);
    initial begin
        ref_in = 4'h0;
        sync_align_input = 1'b0;
    end
    // Half period of two cycles keeps every edge well inside the band
    task burst(input int idx, input int edges);
        repeat (edges) begin
            @(posedge core_clk) ref_in[idx] <= 1'b1;
            repeat (2) @(posedge core_clk);
            ref_in[idx] <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task sync_pulse();
        @(posedge core_clk) sync_align_input <= 1'b1;
        repeat (4) @(posedge core_clk);
        sync_align_input <= 1'b0;
    endtask
endmodule

// ### irp_predivider_monitor.sv
// Concurrent checks on the pre-divider top ports
`timescale 1ns/1ps
module irp_predivider_monitor #(
    parameter int unsigned FRAME_CYCLES = irp_pkg::IRP_FRAME_CYC
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,
    // Inputs watched
    input  wire logic          sync_align_input,
    input  irp_pkg::irp_reg_req_t reg_req,
    // Outputs watched
    input  wire logic [7:0]    reg_rd_data,
    input  wire logic          main_ref_event,
    input  irp_pkg::irp_sel_t  main_sel,
    input  irp_pkg::irp_sel_t  aux_sel,
    input  wire logic          frame_pulse,
    input  wire logic          mframe_pulse
);
    import irp_pkg::*;
    int unsigned gap;
    logic        seen;
    logic [3:0]  sync_age;
    logic [7:0]  div_lo;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gap <= 0;
            seen <= 1'b0;
        end else begin
            gap <= frame_pulse ? 0 : gap + 1;
            seen <= seen | frame_pulse;
        end
    end
    // A sync realigns the frame, so the period check rests for a few cycles
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_age <= 4'h0;
            div_lo <= 8'h01;
        end else begin
            sync_age <= sync_align_input ? 4'h8 : sync_age - (sync_age != 4'h0);
            if (reg_req.wr && reg_req.addr == IRP_OFS_DIV_LO) div_lo <= reg_req.wdata;
        end
    end
    chk_frame_period: assert property ((frame_pulse && seen && sync_age == 4'h0) |->
        gap == FRAME_CYCLES - 1) else $error("frame pulse period wrong");
    chk_frame_late: assert property (seen |-> gap < FRAME_CYCLES)
        else $error("frame pulse missing");
    chk_mframe_sub: assert property (mframe_pulse |-> frame_pulse)
        else $error("multiframe pulse off frame");
    chk_sync_align: assert property ($rose(sync_align_input) |->
        ##[1:3] (frame_pulse && mframe_pulse)) else $error("sync did not realign");
    chk_event_single: assert property (main_ref_event |=> !main_ref_event)
        else $error("reference event longer than one cycle");
    chk_main_id: assert property (main_sel.ok |->
        main_sel.id inside {4'h3, 4'h4, 4'h8, 4'h9}) else $error("main channel id invalid");
    chk_aux_id: assert property (aux_sel.ok |->
        aux_sel.id inside {4'h3, 4'h4, 4'h8, 4'h9}) else $error("aux channel id invalid");
    chk_div_readback: assert property ((reg_req.addr == IRP_OFS_DIV_LO && !reg_req.wr) |=>
        reg_rd_data == div_lo) else $error("divide value readback wrong");
endmodule
bind irp_predivider irp_predivider_monitor #(.FRAME_CYCLES(FRAME_CYCLES)) mon_u (
    .core_clk(core_clk), .rstn(rstn), .sync_align_input(sync_align_input), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data), .main_ref_event(main_ref_event), .main_sel(main_sel),
    .aux_sel(aux_sel), .frame_pulse(frame_pulse), .mframe_pulse(mframe_pulse));

// ### tb_top.sv
// Self-checking bench for the input reference pre-divider
`timescale 1ns/1ps
module tb_top;
    import irp_pkg::*;
    localparam int unsigned FRAME = 200;
    logic         core_clk;
    logic         rstn;
    logic         network_type_pin;
    logic         sync_align_input;
    logic [3:0]   ref_in;
    irp_reg_req_t reg_req;
    logic [7:0]   reg_rd_data;
    logic         main_ref_event;
    logic         aux_ref_event;
    logic         frame_pulse;
    logic         mframe_pulse;
    irp_sel_t     main_sel;
    irp_sel_t     aux_sel;
    int           mismatches;
    int           checks;
    int           cyc;
    int           events;
    int           seed;
    int           nval;
    int           g;
    logic [7:0]   d;
    logic [7:0]   ra [8] = '{8'h22, 8'h23, 8'h27, 8'h28, 8'h18, 8'h19, 8'h1A, 8'h1B};
    logic [7:0]   re [8] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h32, 8'h54, 8'h32, 8'h54};
    logic [7:0]   cfgs [$] = '{8'h00, 8'h80, 8'hC0, 8'h42, 8'h48};
    irp_predivider #(.FRAME_CYCLES(FRAME)) dut_u (.core_clk(core_clk), .rstn(rstn),
        .ref_in(ref_in), .sync_align_input(sync_align_input),
        .network_type_pin(network_type_pin), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .main_ref_event(main_ref_event), .aux_ref_event(aux_ref_event), .main_sel(main_sel),
        .aux_sel(aux_sel), .frame_pulse(frame_pulse), .mframe_pulse(mframe_pulse));
    irp_ref_src src_u (.core_clk(core_clk), .ref_in(ref_in),
        .sync_align_input(sync_align_input));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk) reg_req <= '{1'b1, a, v};
        @(posedge core_clk) reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk) reg_req.addr <= a;
        repeat (2) @(posedge core_clk);
        #1 v = reg_rd_data;
    endtask
    task automatic frame_gap(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (frame_pulse !== 1'b1 && n < 1000);
    endtask
    // Bench model of the pre-divider ratio for the configuration bytes in cfgs
    function automatic int ratio(input logic [7:0] cfg, input int n);
        if (cfg[IRP_MAN_BIT]) return n + 1;
        if (cfg[IRP_AUTO_BIT]) return (cfg[3:0] == 4'h2) ? 810 : 1;
        return 1;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (main_ref_event === 1'b1) events++;
        if (cyc == 40000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        seed = 32'h4a27_81a0;
        rstn = 1'b0;
        network_type_pin = 1'b1;
        reg_req = '0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        foreach (ra[i]) begin
            rd(ra[i], d);
            check("reset value", d, re[i]);
        end
        rd(IRP_OFS_INMODE, d);
        check("network bit", {7'h00, d[IRP_NET_BIT]}, 8'h01);
        wr(IRP_OFS_INMODE, 8'h00);
        rd(IRP_OFS_INMODE, d);
        check("network bit", {7'h00, d[IRP_NET_BIT]}, 8'h00);
        // Monitors off so every input counts as valid at once
        wr(IRP_OFS_MONCFG, 8'h00);
        repeat (4) @(posedge core_clk);
        check("main sel", {3'h0, main_sel}, 8'h13);
        wr(IRP_OFS_PRIO_M, 8'h30);
        repeat (4) @(posedge core_clk);
        check("main sel", {3'h0, main_sel}, 8'h14);
        check("aux sel", {3'h0, aux_sel}, 8'h13);
        wr(IRP_OFS_PATH, 8'h07);
        repeat (4) @(posedge core_clk);
        check("forced sel", {3'h0, main_sel}, 8'h19);
        wr(IRP_OFS_PATH, 8'h00);
        wr(IRP_OFS_PRIO_M, 8'h32);
        foreach (cfgs[i]) begin
            nval = 1 + ($unsigned($random(seed)) % 6);
            wr(IRP_FREQ_OFS[0], cfgs[i]);
            wr(IRP_OFS_DIV_LO, 8'(nval));
            wr(IRP_OFS_DIV_HI, 8'h00);
            repeat (4) @(posedge core_clk);
            events = 0;
            src_u.burst(0, 3 * ratio(cfgs[i], nval));
            repeat (6) @(posedge core_clk);
            check("main events", 8'(events), 8'h03);
        end
        // Falling edges land two cycles later than rising ones would
        wr(IRP_OFS_TEST, 8'h04);
        events = 0;
        src_u.burst(0, 3);
        #1 check("falling early", 8'(events), 8'h02);
        repeat (6) @(posedge core_clk);
        check("falling events", 8'(events), 8'h03);
        wr(IRP_OFS_BUCKET, 8'h00);
        wr(IRP_OFS_MONCFG, 8'h01);
        repeat (300) @(posedge core_clk);
        check("idle input dropped", {3'h0, main_sel}, 8'h14);
        // Start the sync right after a natural pulse so the two cannot be confused
        frame_gap(g);
        fork
            src_u.sync_pulse();
        join_none
        frame_gap(g);
        check("sync delay", {7'h00, g <= 4}, 8'h01);
        check("mframe at sync", {7'h00, mframe_pulse}, 8'h01);
        frame_gap(g);
        check("frame gap", 8'(g), 8'(FRAME));
        wr(IRP_OFS_PRIO_A, 8'h03);
        repeat (4) @(posedge core_clk);
        check("aux own sel", {3'h0, aux_sel}, 8'h18);
        wr(IRP_OFS_PATH, 8'h40);
        frame_gap(g);
        @(posedge core_clk);
        #1 check("aux follow event", {7'h00, aux_ref_event}, 8'h01);
        check("aux follow sel", {3'h0, aux_sel}, 8'h14);
        end_sim();
    end
endmodule
